// File: hdl/sscd_pkg.sv
// Shared constants and types for the synchronous SRAM cycle decoder.
// Assumes one 100 MHz clock; every user of these names writes sscd_pkg::name.
package sscd_pkg;

    // ============================================================
    // Array geometry
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int BYTE_W  = 8;
    localparam int BURST_W = 2;
    localparam int WQ_W    = ADDR_W + LANES + DATA_W;

    // ============================================================
    // Write queue between the pins and the array
    localparam int WQ_DEPTH = 8;

    // ============================================================
    // Clock and sleep timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEEP_TIME_NS = 20;
    localparam int SLEEP_CYC     = (SLEEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ============================================================
    // Field values
    localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
    localparam logic [LANES-1:0]   LANES_ALL  = 4'hF;
    localparam logic [BURST_W-1:0] CNT_ZERO   = 2'h0;
    localparam logic [BURST_W-1:0] CNT_STEP   = 2'h1;

    // Cycle now in progress on the data lines.
    typedef enum logic [1:0] {
        CYC_IDLE  = 2'b00,
        CYC_READ  = 2'b01,
        CYC_WRITE = 2'b10
    } sscd_cyc_t;

endpackage : sscd_pkg

// File: hdl/sscd_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on the same clock; read data come from the storage flops.
module sscd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
    logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
    logic [PW:0]      count_r, count_nxt;
    logic             push, pop;

    // ============================================================
    // Honest flags: full and empty come straight from the count.
    assign in_ready  = (count_r != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count_r != '0);
    assign out_data  = store_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count arithmetic; pointers wrap at DEPTH.
    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push)
            wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
        if (pop)
            rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
        if (push && !pop)
            count_nxt = count_r + (PW+1)'(1);
        else if (pop && !push)
            count_nxt = count_r - (PW+1)'(1);
    end

    // Register the pointers and the count.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // Storage carries no reset; a slot is only used after a word has been pushed into it.
    always_ff @(posedge core_clk)
    begin
        if (push)
            store_r[wr_ptr_r] <= in_data;
    end

endmodule : sscd_fifo

// File: hdl/sscd_mem.sv
// Byte-writable array with one write port and one registered read port.
// Assumes the caller keeps the read enable low when no read is wanted.
module sscd_mem (
    // Clock.
    input  wire logic                         core_clk,
    // Write port.
    input  wire logic                         wr_en,
    input  wire logic [sscd_pkg::ADDR_W-1:0]  wr_addr,
    input  wire logic [sscd_pkg::LANES-1:0]   wr_lanes,
    input  wire logic [sscd_pkg::DATA_W-1:0]  wr_data,
    // Read port.
    input  wire logic                         rd_en,
    input  wire logic [sscd_pkg::ADDR_W-1:0]  rd_addr,
    output logic [sscd_pkg::DATA_W-1:0]       rd_data
);
    localparam int WORDS = 1 << sscd_pkg::ADDR_W;

    // ============================================================
    // One byte-wide bank per lane so a lane write leaves the others alone.
    for (genvar g = 0; g < sscd_pkg::LANES; g++)
    begin : g_lane
        logic [sscd_pkg::BYTE_W-1:0] bank_r [WORDS];

        // Write the lane when its enable is set.
        always_ff @(posedge core_clk)
        begin
            if (wr_en && wr_lanes[g])
                bank_r[wr_addr] <= wr_data[g*sscd_pkg::BYTE_W +: sscd_pkg::BYTE_W];
        end

        // Read data leave through a register for the pipelined output.
        always_ff @(posedge core_clk)
        begin
            if (rd_en)
                rd_data[g*sscd_pkg::BYTE_W +: sscd_pkg::BYTE_W] <= bank_r[rd_addr];
        end
    end

endmodule : sscd_mem

// File: hdl/sscd_top.sv
// Cycle decoder and data-lane control of a pipelined synchronous 32-bit SRAM.
// Assumes the bus pins are sampled on core_clk; output enable is asynchronous,
// the sleep request and burst mode pins are synchronised here.
//
// Function
// - Processor strobe while selected and awake always starts read.
// - Controller strobe with write request starts write.
// - Controller strobe without write starts read burst.
// - No strobe, step low: continue at next address.
// - No strobe, step high: repeat current address.
// - Write request from global or byte-lane enables.
// - Global write takes all lanes, byte write exactly those whose enables are low.
// - Data lines follow current cycle and output enable.
// - Output enable asynchronous, masked during writes.
// - Read drives all bits unless disabled, deselected or asleep.
// - Read data appear one cycle after address.
// - Deselect on strobe with inactive chip selects; processor strobe needs first select low.
// - Sleep tri-states in two cycles, two to exit.
// - Burst counter interleaved when mode high, else linear.
module sscd_top (
    // Clock and reset.
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // Address and selects.
    input  wire logic [sscd_pkg::ADDR_W-1:0]  addr,
    input  wire logic                         chip_sel_n_a,
    input  wire logic                         chip_sel_b,
    input  wire logic                         chip_sel_n_c,
    // Burst control.
    input  wire logic                         proc_addr_strobe_n,
    input  wire logic                         ctrl_addr_strobe_n,
    input  wire logic                         burst_step_n,
    input  wire logic                         burst_mode,
    // Write controls.
    input  wire logic                         global_write_n,
    input  wire logic                         byte_write_en_n,
    input  wire logic [sscd_pkg::LANES-1:0]   byte_lane_write_n,
    // Asynchronous controls.
    input  wire logic                         out_en_n,
    input  wire logic                         sleep_req,
    // Common data lines.
    input  wire logic [sscd_pkg::DATA_W-1:0]  dq_in,
    output logic [sscd_pkg::DATA_W-1:0]       dq_out,
    output logic                              dq_oe,
    // Status.
    output logic                              wr_buf_ready,
    output logic                              asleep
);
    localparam int AW = sscd_pkg::ADDR_W;
    localparam int BW = sscd_pkg::BURST_W;

    sscd_pkg::sscd_cyc_t          cyc_r, cyc_nxt;
    logic [AW-1:0]                addr_r, addr_nxt;
    logic [BW-1:0]                base_r, base_nxt;
    logic [BW-1:0]                cnt_r, cnt_nxt;
    logic                         rd_valid_r, rd_valid_nxt;
    logic                         sleep_meta_r, sleep_s_r;
    logic                         mode_meta_r, mode_s_r;
    logic                         selected;
    logic                         proc_start;
    logic                         any_start;
    logic [sscd_pkg::LANES-1:0]   wr_lanes;
    logic                         wr_req;
    logic                         push;
    logic [sscd_pkg::WQ_W-1:0]    wq_in;
    logic [sscd_pkg::WQ_W-1:0]    wq_out;
    logic                         wq_valid;

    // ============================================================
    // Low address bits of a burst step, from the start bits and the count.
    function automatic logic [BW-1:0] sscd_burst_low(
        input logic [BW-1:0] base,
        input logic [BW-1:0] cnt,
        input logic          ilv
    );
        sscd_burst_low = ilv ? (base ^ cnt) : (base + cnt);
    endfunction : sscd_burst_low

    // ============================================================
    // Sleep and mode pins come from outside the clock's domain.
    // Two flops on sleep also give the two-cycle entry and exit delay.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sleep_meta_r <= 1'b0;
            sleep_s_r    <= 1'b0;
            mode_meta_r  <= 1'b1;
            mode_s_r     <= 1'b1;
        end
        else
        begin
            sleep_meta_r <= sleep_req;
            sleep_s_r    <= sleep_meta_r;
            mode_meta_r  <= burst_mode;
            mode_s_r     <= mode_meta_r;
        end
    end

    assign asleep = sleep_s_r;

    // ============================================================
    // Pin decode. The processor strobe counts only while the first select is low.
    assign selected   = ~chip_sel_n_a & chip_sel_b & ~chip_sel_n_c;
    assign proc_start = ~proc_addr_strobe_n & ~chip_sel_n_a;
    assign any_start  = proc_start | ~ctrl_addr_strobe_n;

    // Lane enables: global write takes all four, else with byte write enabled the low lane inputs, else none.
    always_comb
    begin
        if (!global_write_n)
            wr_lanes = sscd_pkg::LANES_ALL;
        else if (!byte_write_en_n)
            wr_lanes = ~byte_lane_write_n;
        else
            wr_lanes = sscd_pkg::LANES_NONE;
    end

    assign wr_req = |wr_lanes;

    // ============================================================
    // Next cycle. A new strobe outranks continue and suspend; the processor
    // strobe forces a read because its write controls arrive a clock later.
    always_comb
    begin
        cyc_nxt  = cyc_r;
        addr_nxt = addr_r;
        base_nxt = base_r;
        cnt_nxt  = cnt_r;
        if (sleep_s_r)
            cyc_nxt = sscd_pkg::CYC_IDLE;
        else if (any_start)
        begin
            if (selected)
            begin
                addr_nxt = addr;
                base_nxt = addr[BW-1:0];
                cnt_nxt  = sscd_pkg::CNT_ZERO;
                if (!proc_start && wr_req)
                    cyc_nxt = sscd_pkg::CYC_WRITE;
                else
                    cyc_nxt = sscd_pkg::CYC_READ;
            end
            else
                cyc_nxt = sscd_pkg::CYC_IDLE;
        end
        else if (cyc_r != sscd_pkg::CYC_IDLE)
        begin
            // A burst goes on whatever the selects now show.
            if (!burst_step_n)
                cnt_nxt = cnt_r + sscd_pkg::CNT_STEP;
            addr_nxt = {addr_r[AW-1:BW], sscd_burst_low(base_r, cnt_nxt, mode_s_r)};
            cyc_nxt  = wr_req ? sscd_pkg::CYC_WRITE : sscd_pkg::CYC_READ;
        end
    end

    // A read launched now has data one edge later; deselect drops it at once.
    assign rd_valid_nxt = (cyc_r == sscd_pkg::CYC_READ) && (cyc_nxt != sscd_pkg::CYC_IDLE);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cyc_r      <= sscd_pkg::CYC_IDLE;
            addr_r     <= '0;
            base_r     <= sscd_pkg::CNT_ZERO;
            cnt_r      <= sscd_pkg::CNT_ZERO;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            cyc_r      <= cyc_nxt;
            addr_r     <= addr_nxt;
            base_r     <= base_nxt;
            cnt_r      <= cnt_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // ============================================================
    // Data drivers. Output enable is used raw, never clocked, and a write
    // cycle masks it so a late output enable cannot fight incoming data.
    assign dq_oe = rd_valid_r & (cyc_r != sscd_pkg::CYC_WRITE) & ~out_en_n & ~sleep_s_r;

    // ============================================================
    // Write data queue. Words are drained into the array every cycle except
    // in sleep; a write that finds the queue full is lost, so the status pin
    // tells the controller to hold off.
    assign push  = (cyc_nxt == sscd_pkg::CYC_WRITE);
    assign wq_in = {addr_nxt, wr_lanes, dq_in};

    sscd_fifo #(
        .WIDTH (sscd_pkg::WQ_W),
        .DEPTH (sscd_pkg::WQ_DEPTH)
    ) u_wq (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (wr_buf_ready),
        .in_data   (wq_in),
        .out_valid (wq_valid),
        .out_ready (~sleep_s_r),
        .out_data  (wq_out)
    );

    // Array; read data register straight onto the data lines.
    sscd_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (wq_valid & ~sleep_s_r),
        .wr_addr  (wq_out[sscd_pkg::WQ_W-1 -: AW]),
        .wr_lanes (wq_out[sscd_pkg::DATA_W +: sscd_pkg::LANES]),
        .wr_data  (wq_out[sscd_pkg::DATA_W-1:0]),
        .rd_en    (cyc_r == sscd_pkg::CYC_READ),
        .rd_addr  (addr_r),
        .rd_data  (dq_out)
    );

    // ============================================================
    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_awake;
        !sleep_s_r;
    endsequence

    sequence s_rd_start;
        s_awake ##0 (proc_start || !ctrl_addr_strobe_n) && selected && (proc_start || !wr_req);
    endsequence

    sequence s_rd_hold;
        s_awake ##0 proc_addr_strobe_n && ctrl_addr_strobe_n && !wr_req;
    endsequence

    chk_proc_read_start: assert property (
        s_awake ##0 (proc_start && selected) |=> cyc_r == sscd_pkg::CYC_READ && addr_r == $past(addr))
        else $error("Processor strobe did not start a read.");

    chk_ctrl_write_start: assert property (
        s_awake ##0 (proc_addr_strobe_n && !ctrl_addr_strobe_n && selected && wr_req)
        |=> cyc_r == sscd_pkg::CYC_WRITE && addr_r == $past(addr))
        else $error("Controller strobe did not start a write.");

    chk_ctrl_read_start: assert property (
        s_awake ##0 (proc_addr_strobe_n && !ctrl_addr_strobe_n && selected && !wr_req)
        |=> cyc_r == sscd_pkg::CYC_READ)
        else $error("Controller strobe did not start a read.");

    chk_burst_suspend: assert property (
        s_awake ##0 (!any_start && burst_step_n && cyc_r != sscd_pkg::CYC_IDLE)
        |=> addr_r == $past(addr_r) && (cyc_r == sscd_pkg::CYC_WRITE) == $past(wr_req))
        else $error("Suspended burst moved its address.");

    chk_burst_linear: assert property (
        s_awake ##0 (!any_start && !burst_step_n && !mode_s_r && cyc_r != sscd_pkg::CYC_IDLE)
        |=> addr_r[BW-1:0] == $past(addr_r[BW-1:0]) + sscd_pkg::CNT_STEP)
        else $error("Linear burst step went to the wrong address.");

    chk_burst_ilv_pair: assert property (
        s_rd_start ##1 (s_awake ##0 !any_start && !burst_step_n && mode_s_r)
        |=> addr_r[BW-1:0] == ($past(addr_r[BW-1:0]) ^ sscd_pkg::CNT_STEP))
        else $error("Interleaved burst first step is wrong.");

    chk_lane_write: assert property (
        push && global_write_n |-> wq_in[sscd_pkg::DATA_W +: sscd_pkg::LANES] == ~byte_lane_write_n)
        else $error("Byte-lane write enables decoded wrongly.");

    chk_write_mask: assert property (
        cyc_r == sscd_pkg::CYC_WRITE |-> !dq_oe)
        else $error("Data drivers on during a write cycle.");

    chk_read_latency: assert property (
        s_rd_start ##1 s_rd_hold |=> dq_oe == (!out_en_n && !sleep_s_r))
        else $error("Read data not driven one cycle after the address.");

    chk_deselect_off: assert property (
        any_start && !selected |=> !dq_oe)
        else $error("Outputs still driven after deselect.");

    chk_sleep_entry: assert property (
        sleep_req ##1 sleep_req |=> asleep && !dq_oe)
        else $error("Sleep did not take effect within two cycles.");

    // The first cycle after idle is never driven.
    chk_first_cycle: assert property (
        cyc_r == sscd_pkg::CYC_IDLE |=> !dq_oe)
        else $error("Driven in first cycle after idle.");

    // Output enable high turns drivers off at once.
    chk_oe_disable: assert property (
        out_en_n |-> !dq_oe)
        else $error("Driven with output enable high.");

    // Nothing is driven while asleep.
    chk_sleep_quiet: assert property (
        asleep |-> !dq_oe)
        else $error("Driven while asleep.");

endmodule : sscd_top

// File: test/sscd_bus_model.sv
// Controller model that drives the decoder's synchronous bus pins.
// Assumes one caller; each cyc call sets the pins just after an edge for the next edge.
module sscd_bus_model (
    // Clock.
    input  wire logic                    core_clk,
    // Pins toward the decoder.
    output logic [sscd_pkg::ADDR_W-1:0]  addr,
    output logic                         chip_sel_n_a,
    output logic                         chip_sel_b,
    output logic                         chip_sel_n_c,
    output logic                         proc_addr_strobe_n,
    output logic                         ctrl_addr_strobe_n,
    output logic                         burst_step_n,
    output logic                         burst_mode,
    output logic                         global_write_n,
    output logic                         byte_write_en_n,
    output logic [sscd_pkg::LANES-1:0]   byte_lane_write_n,
    output logic                         out_en_n,
    output logic                         sleep_req,
    output logic [sscd_pkg::DATA_W-1:0]  dq_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ============================================================
    // Bus at rest from time zero: deselected, no strobe, outputs disabled.
    initial
    begin
        {chip_sel_n_a, chip_sel_b, chip_sel_n_c} = 3'h5;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
        {global_write_n, byte_write_en_n, byte_lane_write_n} = 6'h3F;
        {burst_mode, out_en_n, sleep_req} = 3'h6;
        addr = '0;
        dq_in = '0;
    end

    // ============================================================
    // One bus cycle; all pins move together right after an edge.
    task automatic cyc(input logic [2:0] sel, input logic ps_n, input logic cs_n, input logic st_n,
                       input logic [5:0] wr, input logic [15:0] a, input logic [31:0] d);
        logic wrq;
        wrq = !wr[5] || (!wr[4] && (wr[3:0] != 4'hF));
        @(posedge core_clk);
        {chip_sel_n_a, chip_sel_b, chip_sel_n_c} <= sel;
        proc_addr_strobe_n <= ps_n;
        ctrl_addr_strobe_n <= cs_n;
        burst_step_n <= st_n;
        {global_write_n, byte_write_en_n, byte_lane_write_n} <= wr;
        addr <= a;
        // Data go out only with a real write; a released bus never keeps its last value.
        dq_in <= (wrq && ps_n) ? d : ~dq_in;
        // Drivers are turned off before a write starts.
        if (wrq && ps_n)
            out_en_n <= 1'b1;
    endtask : cyc

    // Output enable is moved between edges, as an asynchronous pin may be.
    task automatic set_oe(input logic v);
        #2;
        out_en_n = v;
    endtask : set_oe

    // Sleep and burst order pins; selects and strobes stay at rest meanwhile.
    task automatic pins(input logic zz, input logic md);
        @(posedge core_clk);
        sleep_req <= zz;
        burst_mode <= md;
        {chip_sel_n_a, proc_addr_strobe_n, ctrl_addr_strobe_n} <= 3'h7;
    endtask : pins
endmodule : sscd_bus_model

// File: test/tb_top.sv
// Self-checking bench for the SRAM cycle decoder, driven by the controller model.
// Assumes only the model and the reset here drive the decoder's inputs.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [2:0] SEL_ON  = 3'h2;
    localparam logic [2:0] SEL_OFF = 3'h5;
    localparam logic [5:0] WR_NONE = 6'h3F;
    localparam logic [5:0] WR_ALL  = 6'h1F;

    logic                        core_clk;
    logic                        rst;
    logic [15:0]                 addr;
    logic                        chip_sel_n_a, chip_sel_b, chip_sel_n_c, proc_addr_strobe_n;
    logic                        ctrl_addr_strobe_n, burst_step_n, burst_mode, global_write_n;
    logic                        byte_write_en_n, out_en_n, sleep_req, dq_oe, wr_buf_ready, asleep;
    logic [3:0]                  byte_lane_write_n;
    logic [31:0]                 dq_in, dq_out;
    logic [31:0]                 ref_mem [logic [15:0]];
    int                          n_fail;
    int                          checked;

    sscd_top u_sscd_top (.core_clk, .rst, .addr, .chip_sel_n_a, .chip_sel_b, .chip_sel_n_c,
        .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .burst_mode, .global_write_n,
        .byte_write_en_n, .byte_lane_write_n, .out_en_n, .sleep_req, .dq_in, .dq_out, .dq_oe,
        .wr_buf_ready, .asleep);

    sscd_bus_model u_sscd_bus_model (.core_clk, .addr, .chip_sel_n_a, .chip_sel_b, .chip_sel_n_c,
        .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .burst_mode, .global_write_n,
        .byte_write_en_n, .byte_lane_write_n, .out_en_n, .sleep_req, .dq_in);

    // ============================================================
    // Shared helpers.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Burst address: only the two low bits move, with wraparound.
    function automatic logic [15:0] baddr(input logic [15:0] a, input logic [1:0] n, input logic ilv);
        baddr = {a[15:2], ilv ? (a[1:0] ^ n) : (a[1:0] + n)};
    endfunction : baddr

    // Deselect through the controller strobe with the first select off.
    task automatic idle;
        u_sscd_bus_model.cyc(SEL_OFF, 1'b1, 1'b0, 1'b1, WR_NONE, '0, '0);
    endtask : idle

    // Read burst of n words, each judged one edge after its address edge.
    task automatic rd_burst(input logic [15:0] a, input logic ilv, input logic st_n, input int n);
        u_sscd_bus_model.set_oe(1'b0);
        u_sscd_bus_model.cyc(SEL_ON, 1'b1, 1'b0, st_n, WR_NONE, a, '0);
        for (int i = 0; i <= n; i++)
        begin
            u_sscd_bus_model.cyc(SEL_OFF, 1'b1, 1'b1, st_n, WR_NONE, '0, '0);
            if (i > 0)
            begin
                #1;
                chk(dq_oe, 1'b1, "read drive");
                chk(dq_out, ref_mem[baddr(a, st_n ? 2'h0 : 2'(i - 1), ilv)], "read data");
            end
        end
        idle();
    endtask : rd_burst

    // Single write started by the controller strobe; the model keeps lanes not written.
    task automatic wr1(input logic [15:0] a, input logic [5:0] wr, input logic [31:0] d);
        u_sscd_bus_model.cyc(SEL_ON, 1'b1, 1'b0, 1'b1, wr, a, d);
        for (int b = 0; b < 4; b++)
            if (!wr[5] || (!wr[4] && !wr[b]))
                ref_mem[a][8*b +: 8] = d[8*b +: 8];
        idle();
    endtask : wr1

    // ============================================================
    // Scenarios.
    // Write burst in interleaved order, selects dropped after the start.
    task automatic sc_write_burst;
        for (int i = 0; i < 4; i++)
        begin
            u_sscd_bus_model.cyc(i == 0 ? SEL_ON : SEL_OFF, 1'b1, i != 0, 1'b0, WR_ALL, 16'h0011,
                                 32'hA5A5_0000 + i);
            ref_mem[baddr(16'h0011, 2'(i), 1'b1)] = 32'hA5A5_0000 + i;
            if (i == 2)
            begin
                u_sscd_bus_model.set_oe(1'b0);
                #1;
                chk(dq_oe, 1'b0, "write drive");
            end
        end
        idle();
        #1;
        chk(wr_buf_ready, 1'b1, "queue room");
    endtask : sc_write_burst

    // Linear and interleaved read bursts, then a suspended one.
    task automatic sc_read_bursts;
        u_sscd_bus_model.pins(1'b0, 1'b0);
        idle();
        idle();
        rd_burst(16'h0012, 1'b0, 1'b0, 4);
        u_sscd_bus_model.pins(1'b0, 1'b1);
        idle();
        idle();
        rd_burst(16'h0013, 1'b1, 1'b0, 4);
        rd_burst(16'h0011, 1'b1, 1'b1, 3);
    endtask : sc_read_bursts

    // Every kind of write request, each read back at once.
    task automatic sc_byte_lanes;
        logic [5:0] tbl [8] = '{6'h1F, 6'h2E, 6'h2D, 6'h2B, 6'h27, 6'h2A, 6'h2F, 6'h30};
        for (int j = 0; j < 8; j++)
        begin
            wr1(16'h0020, tbl[j], 32'(32'h1111_1111 * (j + 1)));
            rd_burst(16'h0020, 1'b1, 1'b1, 1);
        end
    endtask : sc_byte_lanes

    // Processor strobe ignores write inputs; a later suspend edge writes.
    task automatic sc_proc;
        wr1(16'h0030, WR_ALL, 32'hC0DE_0030);
        u_sscd_bus_model.cyc(SEL_ON, 1'b0, 1'b1, 1'b1, WR_ALL, 16'h0030, 32'hDEAD_BEEF);
        idle();
        rd_burst(16'h0030, 1'b1, 1'b1, 1);
        u_sscd_bus_model.cyc(SEL_ON, 1'b0, 1'b1, 1'b1, WR_NONE, 16'h0030, '0);
        u_sscd_bus_model.cyc(SEL_OFF, 1'b1, 1'b1, 1'b1, WR_ALL, '0, 32'h5A5A_5A5A);
        idle();
        ref_mem[16'h0030] = 32'h5A5A_5A5A;
        rd_burst(16'h0030, 1'b1, 1'b1, 1);
    endtask : sc_proc

    // Output enable follows at once mid-cycle; deselect turns drivers off.
    task automatic sc_oe_desel;
        u_sscd_bus_model.set_oe(1'b0);
        u_sscd_bus_model.cyc(SEL_ON, 1'b1, 1'b0, 1'b1, WR_NONE, 16'h0010, '0);
        u_sscd_bus_model.cyc(3'h6, 1'b0, 1'b1, 1'b1, WR_NONE, 16'h0011, '0);
        #1;
        chk(dq_oe, 1'b0, "first cycle");
        u_sscd_bus_model.cyc(3'h0, 1'b0, 1'b1, 1'b1, WR_NONE, '0, '0);
        #1;
        chk(dq_oe, 1'b1, "strobe ignored");
        u_sscd_bus_model.set_oe(1'b1);
        #1;
        chk(dq_oe, 1'b0, "enable high");
        u_sscd_bus_model.set_oe(1'b0);
        #1;
        chk(dq_oe, 1'b1, "enable again");
        u_sscd_bus_model.cyc(SEL_OFF, 1'b1, 1'b1, 1'b1, WR_NONE, '0, '0);
        #1;
        chk(dq_oe, 1'b0, "deselected");
        idle();
    endtask : sc_oe_desel

    // Sleep takes exactly two edges to enter and two to leave.
    task automatic sc_sleep;
        for (int k = 0; k < 2; k++)
        begin
            u_sscd_bus_model.pins(k == 0, 1'b1);
            @(posedge core_clk);
            #1;
            chk(asleep, k != 0, "sleep early");
            @(posedge core_clk);
            #1;
            chk(asleep, k == 0, "sleep settled");
            chk(dq_oe, 1'b0, "sleep drive");
        end
        rd_burst(16'h0010, 1'b1, 1'b0, 1);
    endtask : sc_sleep

    // ============================================================
    // Clock, watchdog, main sequence and verdict.
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // The run is about a hundred and fifteen cycles; this limit only cuts a hang short.
    initial
    begin
        #100000;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        n_fail = 0;
        checked = 0;
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk(dq_oe, 1'b0, "reset drive");
        chk(wr_buf_ready, 1'b1, "reset room");
        @(posedge core_clk);
        rst <= 1'b0;
        sc_write_burst();
        sc_read_bursts();
        sc_byte_lanes();
        sc_proc();
        sc_oe_desel();
        sc_sleep();
        give_verdict();
    end
endmodule : tb_top
